// *** core/second_stage_loop_divider_ctrl.sv ***
/*
 * Second-stage loop divider control: reference input divider, loop
 * feedback divider with power-down and sync phase, loop filter bypass.
 * Registers are reached over an Avalon-MM slave with waitrequest.
 * Assumes the reference and VCO-divider inputs are slow against the
 * core clock (below a quarter of it), since they are sampled as data.
 */
`timescale 1ns/1ps
`default_nettype none
module second_stage_loop_divider_ctrl #(
	parameter int REF_W = second_stage_loop_pkg::REF_DIV_W,
	parameter int FB_W = second_stage_loop_pkg::FB_DIV_W,
	parameter int PH_W = second_stage_loop_pkg::PHASE_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Avalon-MM slave
	input wire logic [second_stage_loop_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [second_stage_loop_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [second_stage_loop_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Clock pins and sync
	input wire logic i_ref_in,
	input wire logic i_vco_div_in,
	input wire logic i_sync,
	// Divided clocks
	output logic o_ref_div_clk,
	output logic o_fb_div_clk,
	// Loop filter control
	output logic [second_stage_loop_pkg::LOOP_FILTER_W-1:0]
		o_loop_filter_ctrl,
	output logic o_zero_res_bypass
);

	localparam int DW = second_stage_loop_pkg::DATA_W;
	localparam int RW = second_stage_loop_pkg::REG_W;

	// Bus state
	logic wait_q;
	logic req;
	logic fire;
	logic wr_fire;

	// Software registers
	logic [RW-1:0] lf_low_q;
	logic bypass_q;
	logic [REF_W-1:0] ref_field_q;
	logic [FB_W-1:0] fb_field_q;
	logic [PH_W-1:0] phase_q;
	logic pd_q;
	logic ref_reload_q;

	// Pin synchronisers: bit 0 feeds only bit 1, bit 2 is edge history
	logic [2:0] ref_sync_q;
	logic [2:0] vco_sync_q;
	logic [1:0] sync_sync_q;
	logic ref_tick;
	logic vco_tick;
	logic sync_lvl;

	// Feedback sequencing
	second_stage_loop_pkg::fb_state_t fb_state_q;
	second_stage_loop_pkg::fb_state_t fb_state_d;
	logic [PH_W-1:0] delay_q;
	logic fb_clear;
	logic fb_tick;
	logic [FB_W:0] fb_half;
	logic [REF_W-1:0] ref_half;

	// Reference ratio: field zero behaves as one
	function automatic logic [REF_W-1:0] ref_ratio(
		input logic [REF_W-1:0] field
	);
		if (field == '0) begin
			ref_ratio = REF_W'(1);
		end else begin
			ref_ratio = field;
		end
	endfunction

	function automatic logic [DW-1:0] read_mux(
		input logic [second_stage_loop_pkg::ADDR_W-1:0] addr,
		input second_stage_loop_pkg::fb_state_t st
	);
		logic [DW-1:0] v;
		v = '0;
		if (addr == second_stage_loop_pkg::ADDR_LOOP_FILTER_LOW) begin
			v[RW-1:0] = lf_low_q;
		end else if (addr == second_stage_loop_pkg::ADDR_BYPASS) begin
			v[second_stage_loop_pkg::BYPASS_BIT] = bypass_q; // [RULE10]
		end else if (addr == second_stage_loop_pkg::ADDR_REF_DIV) begin
			v[REF_W-1:0] = ref_field_q; // [RULE10]
		end else if (addr == second_stage_loop_pkg::ADDR_FB_DIV) begin
			v[FB_W-1:0] = fb_field_q;
		end else if (addr == second_stage_loop_pkg::ADDR_PHASE_POWER) begin
			v[PH_W-1:0] = phase_q; // [RULE10]
			v[second_stage_loop_pkg::PD_BIT] = pd_q;
		end else if (addr == second_stage_loop_pkg::ADDR_STATUS) begin
			v[second_stage_loop_pkg::ST_STATE_LSB +: 2] = st;
			v[second_stage_loop_pkg::ST_FB_OUT_BIT] = o_fb_div_clk;
			v[second_stage_loop_pkg::ST_REF_OUT_BIT] = o_ref_div_clk;
			v[second_stage_loop_pkg::ST_SYNC_BIT] = sync_lvl;
		end else begin
			v = '0;
		end
		read_mux = v;
	endfunction

	// Bus handshake: one wait cycle, then the access completes
	assign req = i_avs_read | i_avs_write;
	assign fire = req & ~wait_q;
	assign wr_fire = fire & i_avs_write &
		i_avs_byteenable[second_stage_loop_pkg::BE_LOW_LANE];

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(req & wait_q);
		end
	end

	assign o_avs_waitrequest = wait_q;

	// Read data captured as waitrequest falls, so it stands with it
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read & wait_q) begin
			o_avs_readdata <= read_mux(i_avs_address, fb_state_q);
		end
	end

	// Loop filter registers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lf_low_q <= second_stage_loop_pkg::RST_LOOP_FILTER_LOW;
			bypass_q <= second_stage_loop_pkg::RST_BYPASS;
		end else if (wr_fire) begin
			if (i_avs_address ==
				second_stage_loop_pkg::ADDR_LOOP_FILTER_LOW) begin
				lf_low_q <= i_avs_writedata[RW-1:0];
			end else if (i_avs_address ==
				second_stage_loop_pkg::ADDR_BYPASS) begin
				// Upper bits are reserved and dropped [RULE10]
				bypass_q <=
					i_avs_writedata[second_stage_loop_pkg::BYPASS_BIT];
			end
		end
	end

	// Divider registers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ref_field_q <= second_stage_loop_pkg::RST_REF_DIV;
			fb_field_q <= second_stage_loop_pkg::RST_FB_DIV;
			phase_q <= second_stage_loop_pkg::RST_PHASE;
			pd_q <= second_stage_loop_pkg::RST_PD;
		end else if (wr_fire) begin
			if (i_avs_address == second_stage_loop_pkg::ADDR_REF_DIV) begin
				ref_field_q <= i_avs_writedata[REF_W-1:0]; // [RULE10]
			end else if (i_avs_address ==
				second_stage_loop_pkg::ADDR_FB_DIV) begin
				fb_field_q <= i_avs_writedata[FB_W-1:0];
			end else if (i_avs_address ==
				second_stage_loop_pkg::ADDR_PHASE_POWER) begin
				phase_q <= i_avs_writedata[PH_W-1:0];
				pd_q <= i_avs_writedata[second_stage_loop_pkg::PD_BIT];
			end
		end
	end

	// A new reference ratio restarts the reference divider cleanly
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ref_reload_q <= 1'b0;
		end else begin
			ref_reload_q <= wr_fire &
				(i_avs_address == second_stage_loop_pkg::ADDR_REF_DIV);
		end
	end

	// Loop filter outputs: bypass is the top bit of the joint field
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_loop_filter_ctrl <= '0;
			o_zero_res_bypass <= 1'b0;
		end else begin
			o_loop_filter_ctrl <= {bypass_q, lf_low_q}; // [RULE9]
			// External zero resistor is the user's duty when set [RULE8]
			o_zero_res_bypass <= bypass_q; // [RULE8]
		end
	end

	// Pin synchronisers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ref_sync_q <= '0;
			vco_sync_q <= '0;
			sync_sync_q <= '0;
		end else begin
			ref_sync_q <= {ref_sync_q[1:0], i_ref_in};
			vco_sync_q <= {vco_sync_q[1:0], i_vco_div_in};
			sync_sync_q <= {sync_sync_q[0], i_sync};
		end
	end

	// Both edges tick, so one tick is half an input period [RULE6]
	assign ref_tick = ref_sync_q[1] ^ ref_sync_q[2];
	assign vco_tick = vco_sync_q[1] ^ vco_sync_q[2]; // [RULE6]
	assign sync_lvl = sync_sync_q[1];

	// Half-period count equals the ratio, zero read as one [RULE1] [RULE2]
	assign ref_half = ref_ratio(ref_field_q);

	half_tick_divider #(
		.W(REF_W)
	) u_ref_div (
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.i_tick(ref_tick),
		.i_clear(ref_reload_q),
		.i_half(ref_half),
		.o_div_q(o_ref_div_clk)
	);

	// Feedback sequencing: power-down wins, then sync hold, then delay
	always_comb begin
		fb_state_d = fb_state_q;
		if (pd_q) begin
			fb_state_d = second_stage_loop_pkg::FB_OFF; // [RULE4]
		end else if (sync_lvl) begin
			fb_state_d = second_stage_loop_pkg::FB_HOLD; // [RULE5]
		end else begin
			case (fb_state_q)
				second_stage_loop_pkg::FB_OFF: begin
					fb_state_d = second_stage_loop_pkg::FB_RUN;
				end
				second_stage_loop_pkg::FB_HOLD: begin
					// Phase zero means no offset [RULE7]
					if (phase_q == '0) begin
						fb_state_d = second_stage_loop_pkg::FB_RUN;
					end else begin
						fb_state_d = second_stage_loop_pkg::FB_DELAY;
					end
				end
				second_stage_loop_pkg::FB_DELAY: begin
					if (vco_tick && delay_q == PH_W'(1)) begin
						fb_state_d = second_stage_loop_pkg::FB_RUN;
					end
				end
				default: begin
					fb_state_d = second_stage_loop_pkg::FB_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fb_state_q <= second_stage_loop_pkg::FB_OFF;
		end else begin
			fb_state_q <= fb_state_d;
		end
	end

	// Offset counts phase_q half-period ticks after sync release [RULE7]
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			delay_q <= '0;
		end else if (fb_state_q == second_stage_loop_pkg::FB_HOLD) begin
			delay_q <= phase_q; // [RULE5]
		end else if (fb_state_q == second_stage_loop_pkg::FB_DELAY &&
			vco_tick) begin
			delay_q <= delay_q - PH_W'(1); // [RULE6]
		end
	end

	// Held cleared unless running; output low while powered down [RULE4]
	assign fb_clear = (fb_state_q != second_stage_loop_pkg::FB_RUN);
	assign fb_tick = vco_tick & ~fb_clear;
	// Field plus one [RULE3]
	assign fb_half = {1'b0, fb_field_q} + (FB_W+1)'(1);

	half_tick_divider #(
		.W(FB_W + 1)
	) u_fb_div (
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.i_tick(fb_tick),
		.i_clear(fb_clear),
		.i_half(fb_half),
		.o_div_q(o_fb_div_clk)
	);

endmodule
`default_nettype wire

// *** core/second_stage_loop_pkg.sv ***
/*
 * Constants for the second-stage loop divider control block: register
 * indices and byte addresses, field positions, reset values, state codes.
 * Assumes a 32-bit Avalon-MM slave with byte addressing, 8-bit registers
 * in the low byte lane of each word.
 */
// What this block does
// RULE1: The reference divider divides by its 5-bit field, 1 to 31.
// RULE2: A reference field of zero divides by one, like a field of one.
// RULE3: The feedback divider divides by its 8-bit field plus one, 1 to 256.
// RULE4: Power-down set stops the feedback divider, clear (default) runs it.
// RULE5: After a sync the feedback divider starts at its 6-bit phase setting.
// RULE6: Each phase step is half a period of the VCO-divider output clock.
// RULE7: Phase zero gives no offset, 63 gives 31.5 periods, linear in between.
// RULE8: Bypass zeroes the zero resistor; software must add an external one.
// RULE9: Bypass is the top bit of one loop-filter field over two registers.
// RULE10: Reserved bits read as zero and writes to them do nothing.
package second_stage_loop_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int REF_DIV_W = 5;
	localparam int FB_DIV_W = 8;
	localparam int PHASE_W = 6;
	localparam int LOOP_FILTER_W = 9;

	// Register indices; the byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_LOOP_FILTER_LOW = 12'h205;
	localparam logic [ADDR_W-1:0] IDX_BYPASS = 12'h206;
	localparam logic [ADDR_W-1:0] IDX_REF_DIV = 12'h207;
	localparam logic [ADDR_W-1:0] IDX_FB_DIV = 12'h208;
	localparam logic [ADDR_W-1:0] IDX_PHASE_POWER = 12'h209;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h20A;

	localparam logic [ADDR_W-1:0] ADDR_LOOP_FILTER_LOW =
		ADDR_W'(IDX_LOOP_FILTER_LOW * 4);
	localparam logic [ADDR_W-1:0] ADDR_BYPASS = ADDR_W'(IDX_BYPASS * 4);
	localparam logic [ADDR_W-1:0] ADDR_REF_DIV = ADDR_W'(IDX_REF_DIV * 4);
	localparam logic [ADDR_W-1:0] ADDR_FB_DIV = ADDR_W'(IDX_FB_DIV * 4);
	localparam logic [ADDR_W-1:0] ADDR_PHASE_POWER =
		ADDR_W'(IDX_PHASE_POWER * 4);
	localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);

	// Field positions
	localparam int BYPASS_BIT = 0;
	localparam int PD_BIT = 6;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_FB_OUT_BIT = 2;
	localparam int ST_REF_OUT_BIT = 3;
	localparam int ST_SYNC_BIT = 4;
	localparam int BE_LOW_LANE = 0;

	// Reset values
	localparam logic [REG_W-1:0] RST_LOOP_FILTER_LOW = 8'h00;
	localparam logic RST_BYPASS = 1'b0;
	localparam logic [REF_DIV_W-1:0] RST_REF_DIV = 5'h00;
	localparam logic [FB_DIV_W-1:0] RST_FB_DIV = 8'h00;
	localparam logic [PHASE_W-1:0] RST_PHASE = 6'h00;
	localparam logic RST_PD = 1'b0;

	typedef enum logic [1:0] {
		FB_OFF = 2'b00,
		FB_HOLD = 2'b01,
		FB_DELAY = 2'b10,
		FB_RUN = 2'b11
	} fb_state_t;

endpackage

// *** core/half_tick_divider.sv ***
/*
 * Divider counting half-period ticks: the output toggles every i_half
 * ticks, so with a tick on each input edge the output period is i_half
 * input periods.
 * Assumes i_half is never zero and ticks are one core cycle long.
 */
`timescale 1ns/1ps
`default_nettype none
module half_tick_divider #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Control
	input wire logic i_tick,
	input wire logic i_clear,
	input wire logic [W-1:0] i_half,
	// Divided output
	output logic o_div_q
);

	logic [W-1:0] cnt_q;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= '0;
			o_div_q <= 1'b0;
		end else if (i_clear) begin
			cnt_q <= '0;
			o_div_q <= 1'b0;
		end else if (i_tick) begin
			// >= so a ratio lowered mid-count wraps at once
			if (cnt_q >= i_half - W'(1)) begin
				cnt_q <= '0;
				o_div_q <= ~o_div_q;
			end else begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end

endmodule
`default_nettype wire

// *** tb/second_stage_loop_divider_ctrl_checker.sv ***
/* Checker for the divider control block.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module divider_ctrl_checker (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Register bus
	input wire logic [11:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// Pins and outputs
	input wire logic i_sync,
	input wire logic o_fb_div_clk,
	input wire logic [8:0] o_loop_filter_ctrl,
	input wire logic o_zero_res_bypass
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	logic pd_q;
	logic byp_q;
	logic rd_go;
	assign rd_go = i_avs_read & o_avs_waitrequest;
	// Shadow of the power-down bit, taken where a write completes
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pd_q <= 1'b0;
		end else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
			&& i_avs_address == 12'h824) begin
			pd_q <= i_avs_writedata[6];
		end
	end
	// Shadow of the bypass bit, so the output is held against the write
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			byp_q <= 1'b0;
		end else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
			&& i_avs_address == 12'h818) begin
			byp_q <= i_avs_writedata[0];
		end
	end
	a_bus_answer: assert property ((i_avs_read | i_avs_write) &&
		o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not exactly one cycle");
	a_msb_bypass: assert property (
		o_loop_filter_ctrl[8] == o_zero_res_bypass &&
		o_zero_res_bypass == $past(byp_q))
		else $error("filter field msb differs from bypass");
	// Output clears two cycles after the write, one more to be sampled
	a_pd_quiet: assert property (
		pd_q && $past(pd_q) && $past(pd_q, 2) |-> !o_fb_div_clk)
		else $error("feedback runs while powered down");
	a_sync_hold: assert property (i_sync [*5] |=> !o_fb_div_clk)
		else $error("feedback not held during sync");
	a_upper_zero: assert property (rd_go |=> o_avs_readdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_ref_resv: assert property (rd_go && i_avs_address == 12'h81C
		|=> o_avs_readdata[7:5] == 3'h0) else $error("ref reserved bits set");
	a_bypass_read: assert property (rd_go && i_avs_address == 12'h818
		|=> o_avs_readdata[7:0] == {7'h00, o_zero_res_bypass})
		else $error("bypass readback mismatch");
	a_unmapped_zero: assert property (rd_go && i_avs_address > 12'h828
		|=> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
	c_write: cover property (i_avs_write && !o_avs_waitrequest);
	c_pd: cover property (pd_q ##1 pd_q);
	c_sync: cover property ($fell(i_sync));
endmodule
bind second_stage_loop_divider_ctrl divider_ctrl_checker chk_u (.i_core_clk,
	.i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
	.i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_sync,
	.o_fb_div_clk, .o_loop_filter_ctrl, .o_zero_res_bypass);
`default_nettype wire

// *** tb/test_second_stage_loop_divider_ctrl.sv ***
/* Self-checking bench for the divider control block.
   Drives the bus and the clock pins itself; pins run at core/8. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module test_second_stage_loop_divider_ctrl;
	logic i_core_clk = 1'b0, i_arst_n = 1'b0;
	logic [11:0] i_avs_address = 12'h000;
	logic i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
	logic [3:0] i_avs_byteenable = 4'h0;
	logic o_avs_waitrequest, o_ref_div_clk, o_fb_div_clk, o_zero_res_bypass;
	logic i_ref_in = 1'b0, i_vco_div_in = 1'b0, i_sync = 1'b0;
	logic [8:0] o_loop_filter_ctrl;
	logic [1:0] ph = 2'h0;
	logic [31:0] q;
	int errors = 0, cmp_count = 0, cyc = 0, n, base;
	typedef struct {logic [11:0] a; logic [7:0] r, w, e;} row_t;
	row_t rows [6] = '{'{12'h814, 8'h00, 8'hFF, 8'hFF},
		'{12'h818, 8'h00, 8'hFF, 8'h01}, '{12'h81C, 8'h00, 8'hFF, 8'h1F},
		'{12'h820, 8'h00, 8'hAB, 8'hAB}, '{12'h824, 8'h00, 8'hFF, 8'h7F},
		'{12'h82C, 8'h00, 8'hFF, 8'h00}};
	int refs [4] = '{0, 1, 5, 31};
	int fbs [3] = '{0, 2, 255};
	int phs [4] = '{0, 1, 6, 63};
	second_stage_loop_divider_ctrl dut_u (.i_core_clk, .i_arst_n,
		.i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
		.i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_ref_in,
		.i_vco_div_in, .i_sync, .o_ref_div_clk, .o_fb_div_clk,
		.o_loop_filter_ctrl, .o_zero_res_bypass);
	always #12.5 i_core_clk = ~i_core_clk;
	// Pin clocks toggle every 4 core cycles, well under the core/4 limit
	always @(posedge i_core_clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h3) begin
			i_ref_in <= ~i_ref_in;
			i_vco_div_in <= ~i_vco_div_in;
		end
		cyc++;
		if (cyc == 40000) begin
			errors++;
			$display("CHECK FAILED %0t timeout", $time);
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [3:0] be);
		@(posedge i_core_clk);
		i_avs_address <= a;
		i_avs_write <= w;
		i_avs_read <= !w;
		i_avs_writedata <= {24'h000000, d};
		i_avs_byteenable <= be;
		do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	// Cycles up to the next rising edge of the chosen divided output
	task automatic rise(input bit fb, output int k);
		logic p, c;
		c = 1'b1;
		k = 0;
		do begin
			p = c;
			@(posedge i_core_clk);
			c = fb ? o_fb_div_clk : o_ref_div_clk;
			k++;
		end while (!(p === 1'b0 && c === 1'b1));
	endtask
	// First two rises may be cut short by a restart, so skip them
	task automatic period(input bit fb, output int k);
		rise(fb, k);
		rise(fb, k);
		rise(fb, k);
	endtask
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b0, rows[i].a, 8'h00, 4'h0);
			`CHK(q, {24'h0, rows[i].r}, "reset value")
			wr(rows[i].a, rows[i].w);
			bus(1'b0, rows[i].a, 8'h00, 4'h0);
			`CHK(q, {24'h0, rows[i].e}, "readback")
		end
		`CHK(o_loop_filter_ctrl, 9'h1FF, "filter field")
		`CHK(o_zero_res_bypass, 1'b1, "bypass pin")
		n = 0;
		repeat (200) begin
			@(posedge i_core_clk);
			if (o_fb_div_clk !== 1'b0) n++;
		end
		`CHK(n, 0, "feedback quiet")
		bus(1'b1, 12'h81C, 8'h00, 4'hE);
		bus(1'b0, 12'h81C, 8'h00, 4'h0);
		`CHK(q, 32'h1F, "lane write ignored")
		foreach (refs[i]) begin
			wr(12'h81C, 8'(refs[i]));
			period(1'b0, n);
			`CHK(n, 8 * (refs[i] == 0 ? 1 : refs[i]), "ref period")
		end
		wr(12'h824, 8'h00);
		foreach (fbs[i]) begin
			wr(12'h820, 8'(fbs[i]));
			period(1'b1, n);
			`CHK(n, 8 * (fbs[i] + 1), "feedback period")
		end
		wr(12'h820, 8'h03);
		foreach (phs[i]) begin
			wr(12'h824, 8'(phs[i]));
			i_sync <= 1'b1;
			repeat (8) @(posedge i_core_clk);
			do @(posedge i_core_clk); while (ph != 2'h3);
			i_sync <= 1'b0;
			rise(1'b1, n);
			if (i == 0) base = n;
			`CHK(n - base, 4 * phs[i], "phase delay")
		end
		bus(1'b0, 12'h828, 8'h00, 4'h0);
		`CHK(q[1:0], 2'h3, "feedback running")
		`CHK(q[4], 1'b0, "sync seen low")
		i_arst_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		`CHK(o_zero_res_bypass, 1'b0, "bypass after reset")
		bus(1'b0, 12'h81C, 8'h00, 4'h0);
		`CHK(q, 32'h0, "ref after reset")
		end_of_test();
	end
endmodule
`default_nettype wire
